/* rtl/wit_pkg.sv */
// constants, field layouts and bus carrier for the watchdog/interval timer
// assumes a single system clock and one register access per cycle
//
// Notes on behaviour
// - 8-bit up-counter steps on the selected tap while enabled
// - rollover ff to 00 gives overflow output or interval interrupt by mode
// - power-on reset zeroes the count; standby clears enable, so the count drops to 00
// - power-on clears control bits 7..5 and 2..0; standby only 7..5
// - interval flag set by interval overflow; cleared by read as 1, write 0
// - mode bit 0 selects interval interrupt, 1 the watchdog overflow output
// - enable bit 0 holds the count at 00; 1 counts on from current value
// - clock select 000..111 divides by 2,64,128,256,512,1024,4096,8192
// - reserved bits fixed: control 4,3 one; reset reg 5 zero, 4..0 one
// - reset register to 1f on pin reset and standby; survives own reset
// - watchdog flag set by watchdog overflow only; cleared by read, write 0
// - enable bit 1: watchdog overflow resets chip; else only count/control
// - shared write address: key 5a loads count, key a5 loads control
// - word a5/00 to reset register clears watchdog flag, keeps enable
// - key 5a word to reset register copies bit 6 into chip reset enable
// - byte reads: control at 8610, count at 8611, reset register at 8613
// - watchdog overflow drives the overflow output active for 128 cycles
// - chip reset from overflow stays asserted for 512 cycles
// - a count write coinciding with an increment wins; increment dropped

`default_nettype none

package wit_pkg;

	// ****************************************************************
	// addresses and keys
	// ****************************************************************
	localparam logic [31:0] ADDR_COUNT_CTRL_WR = 32'hffff8610;
	localparam logic [31:0] ADDR_RESET_CTRL_WR = 32'hffff8612;
	localparam logic [31:0] ADDR_CTRL_RD       = 32'hffff8610;
	localparam logic [31:0] ADDR_COUNT_RD      = 32'hffff8611;
	localparam logic [31:0] ADDR_RESET_CTRL_RD = 32'hffff8613;
	localparam logic [7:0]  KEY_COUNT          = 8'h5a;
	localparam logic [7:0]  KEY_CONTROL        = 8'ha5;
	localparam logic [7:0]  WATCHDOG_OVERFLOW_FLAG_CLEAR_DATA    = 8'h00;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int          FLAG_BIT           = 7;
	localparam int          MODE_BIT           = 6;
	localparam int          ENABLE_BIT         = 5;
	localparam int          CHIP_RESET_ENABLE_BIT           = 6;
	localparam logic [7:0]  COUNT_RESET        = 8'h00;
	localparam logic [7:0]  COUNT_MAX          = 8'hff;
	localparam logic [7:0]  COUNT_ONE          = 8'h01;
	localparam logic [2:0]  CKS_RESET          = 3'h0;
	localparam logic [1:0]  CTRL_RESERVED      = 2'h3;
	localparam logic [5:0]  RESET_RESERVED     = 6'h1f;
	localparam logic [7:0]  READ_UNMAPPED      = 8'h00;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam logic [7:0]  OVF_PULSE_CYCLES   = 8'h80;
	localparam logic [9:0]  CHIP_RESET_CYCLES  = 10'h200;
	localparam int          PRESCALE_WIDTH     = 13;
	// log2 of each divider, select 7 in the top nibble
	localparam logic [31:0] DIV_LOG2_TABLE     = 32'hdca98761;

	// ****************************************************************
	// register access carrier
	// ****************************************************************
	typedef struct packed {
		logic [31:0] addr;
		logic        write;  // write strobe, one cycle
		logic        read;   // read strobe, one cycle
		logic        word;   // 1 word transfer, 0 byte transfer
		logic [15:0] wdata;  // key in upper byte, data in lower
	} wit_bus_req_type;

endpackage

`default_nettype wire

/* rtl/wit_prescaler.sv */
// free running divider of the system clock giving one-cycle count ticks
// assumes the select is only changed while counting is stopped

`default_nettype none

module wit_prescaler
	import wit_pkg::*;
(
	// clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// tap select
	input  wire logic [2:0] i_clock_select,
	// tick out
	output var  logic       o_tick
);

	// ****************************************************************
	// divider
	// ****************************************************************
	logic [PRESCALE_WIDTH-1:0] div_count;

	function automatic logic [PRESCALE_WIDTH-1:0] tap_mask(
		input logic [2:0] sel);
		logic [3:0] lg;
		lg = DIV_LOG2_TABLE[{sel, 2'h0} +: 4];
		tap_mask = PRESCALE_WIDTH'((14'h0001 << lg) - 14'h0001);
	endfunction

	// free running count
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			div_count <= '0;
		else
			div_count <= div_count + PRESCALE_WIDTH'(1);
	end

	// tick once per divider period of the selected tap
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			o_tick <= 1'b0;
		else
			o_tick <= &(div_count | ~tap_mask(i_clock_select));
	end

endmodule

`default_nettype wire

/* rtl/wit_timer.sv */
// watchdog / interval timer: counter, control, reset control and outputs
// assumes a synchronous register port; reset pin arrives asynchronously

`default_nettype none

module wit_timer
	import wit_pkg::*;
(
	// clock and resets
	input  wire logic                     i_clock,
	input  wire logic                     i_rst,
	input  wire logic                     i_external_reset_n,
	input  wire logic                     i_standby,
	// register port
	input  wire wit_pkg::wit_bus_req_type i_bus,
	output var  logic [7:0]               o_rdata,
	output var  logic                     o_rvalid,
	// events
	output var  logic                     o_overflow_n,
	output var  logic                     o_chip_reset,
	output var  logic                     o_interval_interrupt
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [1:0] ext_sync;
	logic       ext_rst;
	logic [7:0] watchdog_count;
	logic       interval_overflow_flag;
	logic       timer_mode_select;
	logic       count_enable;
	logic [2:0] clock_select;
	logic       watchdog_overflow_flag;
	logic       chip_reset_enable;
	logic       ovf_armed;
	logic       watchdog_overflow_flag_armed;
	logic [7:0] ovf_pulse_count;
	logic [9:0] chip_reset_count;
	logic       tick;
	logic       wr_count;
	logic       wr_control;
	logic       wr_chip_reset_enable;
	logic       wr_watchdog_overflow_flag_clear;
	logic       rd_byte;
	logic       rollover;
	logic       wdt_event;
	logic       iv_event;
	logic       ovf_clear;
	logic       watchdog_overflow_flag_clear;

	// ****************************************************************
	// reset pin synchroniser
	// ****************************************************************
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			ext_sync <= 2'h0;
		else
			ext_sync <= {ext_sync[0], i_external_reset_n};
	end

	assign ext_rst = ~ext_sync[1];

	// ****************************************************************
	// prescaler
	// ****************************************************************
	wit_prescaler i_wit_prescaler (
		.i_clock        (i_clock),
		.i_rst          (i_rst),
		.i_clock_select (clock_select),
		.o_tick         (tick)
	);

	// ****************************************************************
	// write decode: word writes only, keyed
	// ****************************************************************
	function automatic logic word_hit(input wit_bus_req_type b,
		input logic [31:0] a, input logic [7:0] key);
		word_hit = b.write && b.word && b.addr == a && b.wdata[15:8] == key;
	endfunction

	// keys that match neither value decode to nothing
	assign wr_count   = word_hit(i_bus, ADDR_COUNT_CTRL_WR, KEY_COUNT);
	assign wr_control = word_hit(i_bus, ADDR_COUNT_CTRL_WR, KEY_CONTROL);
	assign wr_chip_reset_enable    = word_hit(i_bus, ADDR_RESET_CTRL_WR, KEY_COUNT);
	assign wr_watchdog_overflow_flag_clear = word_hit(i_bus, ADDR_RESET_CTRL_WR, KEY_CONTROL)
		&& i_bus.wdata[7:0] == WATCHDOG_OVERFLOW_FLAG_CLEAR_DATA;
	assign rd_byte    = i_bus.read && !i_bus.word;

	// overflow events
	assign rollover  = tick && count_enable && !wr_count && !ext_rst
		&& watchdog_count == COUNT_MAX;
	assign wdt_event = rollover && timer_mode_select;
	assign iv_event  = rollover && !timer_mode_select;

	assign ovf_clear  = wr_control && !i_bus.wdata[FLAG_BIT] && ovf_armed;
	assign watchdog_overflow_flag_clear = wr_watchdog_overflow_flag_clear && watchdog_overflow_flag_armed;

	// ****************************************************************
	// counter
	// ****************************************************************
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			watchdog_count <= COUNT_RESET;
		else if (ext_rst || !count_enable)
			watchdog_count <= COUNT_RESET;
		else if (wr_count)
			watchdog_count <= i_bus.wdata[7:0];
		else if (tick)
			watchdog_count <= watchdog_count + COUNT_ONE;
	end

	// ****************************************************************
	// control/status fields
	// ****************************************************************
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			timer_mode_select <= 1'b0;
			count_enable      <= 1'b0;
			clock_select      <= CKS_RESET;
		end
		else if (ext_rst || (wdt_event && !wr_control))
		begin
			timer_mode_select <= 1'b0;
			count_enable      <= 1'b0;
			clock_select      <= CKS_RESET;
		end
		else if (i_standby)
		begin
			timer_mode_select <= 1'b0;
			count_enable      <= 1'b0;
		end
		else if (wr_control)
		begin
			timer_mode_select <= i_bus.wdata[MODE_BIT];
			count_enable      <= i_bus.wdata[ENABLE_BIT];
			clock_select      <= i_bus.wdata[2:0];
		end
	end

	// interval flag: a set in the clearing cycle wins
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			interval_overflow_flag <= 1'b0;
		else if (ext_rst)
			interval_overflow_flag <= 1'b0;
		else if (iv_event)
			interval_overflow_flag <= 1'b1;
		else if (i_standby || wdt_event || ovf_clear)
			interval_overflow_flag <= 1'b0;
	end

	// a read seeing the flag set arms its clear
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			ovf_armed <= 1'b0;
		else if (ext_rst || wr_control || !interval_overflow_flag)
			ovf_armed <= 1'b0;
		else if (rd_byte && i_bus.addr == ADDR_CTRL_RD)
			ovf_armed <= 1'b1;
	end

	// ****************************************************************
	// reset control/status
	// ****************************************************************
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			watchdog_overflow_flag <= 1'b0;
		else if (ext_rst)
			watchdog_overflow_flag <= 1'b0;
		else if (wdt_event)
			watchdog_overflow_flag <= 1'b1;
		else if (i_standby || watchdog_overflow_flag_clear)
			watchdog_overflow_flag <= 1'b0;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			watchdog_overflow_flag_armed <= 1'b0;
		else if (ext_rst || wr_watchdog_overflow_flag_clear || !watchdog_overflow_flag)
			watchdog_overflow_flag_armed <= 1'b0;
		else if (rd_byte && i_bus.addr == ADDR_RESET_CTRL_RD)
			watchdog_overflow_flag_armed <= 1'b1;
	end

	// enable bit survives the block's own overflow reset
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			chip_reset_enable <= 1'b0;
		else if (ext_rst || i_standby)
			chip_reset_enable <= 1'b0;
		else if (wr_chip_reset_enable)
			chip_reset_enable <= i_bus.wdata[CHIP_RESET_ENABLE_BIT];
	end

	// ****************************************************************
	// overflow output and chip reset pulses
	// ****************************************************************
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			ovf_pulse_count <= 8'h00;
			o_overflow_n    <= 1'b1;
		end
		else if (ext_rst)
		begin
			ovf_pulse_count <= 8'h00;
			o_overflow_n    <= 1'b1;
		end
		else if (wdt_event)
		begin
			ovf_pulse_count <= OVF_PULSE_CYCLES;
			o_overflow_n    <= 1'b0;
		end
		else if (ovf_pulse_count > 8'h01)
			ovf_pulse_count <= ovf_pulse_count - 8'h01;
		else
		begin
			ovf_pulse_count <= 8'h00;
			o_overflow_n    <= 1'b1;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			chip_reset_count <= 10'h000;
			o_chip_reset     <= 1'b0;
		end
		else if (ext_rst)
		begin
			chip_reset_count <= 10'h000;
			o_chip_reset     <= 1'b0;
		end
		else if (wdt_event && chip_reset_enable)
		begin
			chip_reset_count <= CHIP_RESET_CYCLES;
			o_chip_reset     <= 1'b1;
		end
		else if (chip_reset_count > 10'h001)
			chip_reset_count <= chip_reset_count - 10'h001;
		else
		begin
			chip_reset_count <= 10'h000;
			o_chip_reset     <= 1'b0;
		end
	end

	// interrupt request follows the interval flag
	assign o_interval_interrupt = interval_overflow_flag;

	// ****************************************************************
	// byte read port
	// ****************************************************************
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_rdata  <= READ_UNMAPPED;
			o_rvalid <= 1'b0;
		end
		else
		begin
			o_rvalid <= rd_byte;
			if (!rd_byte)
				o_rdata <= READ_UNMAPPED;
			else if (i_bus.addr == ADDR_CTRL_RD)
				o_rdata <= {interval_overflow_flag, timer_mode_select,
					count_enable, CTRL_RESERVED, clock_select};
			else if (i_bus.addr == ADDR_COUNT_RD)
				o_rdata <= watchdog_count;
			else if (i_bus.addr == ADDR_RESET_CTRL_RD)
				o_rdata <= {watchdog_overflow_flag, chip_reset_enable,
					RESET_RESERVED};
			else
				o_rdata <= READ_UNMAPPED;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	property p_count_step;
		count_enable && tick && !wr_count && !ext_rst
		|=> watchdog_count == 8'($past(watchdog_count) + COUNT_ONE);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("count did not step on tick");

	property p_hold_off;
		!count_enable |=> watchdog_count == COUNT_RESET;
	endproperty
	a_hold_off: assert property (p_hold_off)
		else $error("disabled count not held at zero");

	property p_write_wins;
		count_enable && wr_count && !ext_rst
		|=> watchdog_count == $past(i_bus.wdata[7:0]);
	endproperty
	a_write_wins: assert property (p_write_wins)
		else $error("count write lost to increment");

	property p_iv_flag;
		iv_event |=> interval_overflow_flag && o_overflow_n;
	endproperty
	a_iv_flag: assert property (p_iv_flag)
		else $error("interval overflow did not set flag");

	property p_watchdog_overflow_flag_set;
		wdt_event |=> watchdog_overflow_flag
			&& (!count_enable || $past(wr_control));
	endproperty
	a_watchdog_overflow_flag_set: assert property (p_watchdog_overflow_flag_set)
		else $error("watchdog overflow did not set flag");

	property p_ovf_width;
		wdt_event |=> (!o_overflow_n) [*8] ##120 !o_overflow_n
			##1 o_overflow_n;
	endproperty
	a_ovf_width: assert property (p_ovf_width)
		else $error("overflow output not 128 cycles");

	property p_chip_width;
		wdt_event && chip_reset_enable
		|=> o_chip_reset ##[511:511] o_chip_reset ##1 !o_chip_reset;
	endproperty
	a_chip_width: assert property (p_chip_width)
		else $error("chip reset not 512 cycles");

	property p_bad_key;
		i_bus.write && i_bus.addr == ADDR_COUNT_CTRL_WR
		&& i_bus.wdata[15:8] != KEY_COUNT
		&& i_bus.wdata[15:8] != KEY_CONTROL
		&& !wdt_event && !i_standby && !ext_rst
		|=> $stable(clock_select) && $stable(timer_mode_select);
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("unkeyed write changed control");

	property p_chip_reset_enable_write;
		wr_chip_reset_enable && !ext_rst && !i_standby
		|=> chip_reset_enable == $past(i_bus.wdata[CHIP_RESET_ENABLE_BIT]);
	endproperty
	a_chip_reset_enable_write: assert property (p_chip_reset_enable_write)
		else $error("chip reset enable not loaded");

	property p_reserved;
		rd_byte && i_bus.addr == ADDR_RESET_CTRL_RD
		|=> o_rvalid && o_rdata[5:0] == RESET_RESERVED;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits read wrong");

	property p_standby;
		i_standby && !ext_rst && !count_enable
		|=> !count_enable && !chip_reset_enable
			&& $stable(clock_select) && $stable(watchdog_count);
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby clear wrong");

	c_iv_event:   cover property (iv_event);
	c_wdt_rst:    cover property (wdt_event && chip_reset_enable);
	c_ovf_clear:  cover property (interval_overflow_flag ##1 ovf_clear);
	c_watchdog_overflow_flag_clear: cover property (watchdog_overflow_flag_clear);

endmodule

`default_nettype wire

/* verification/wit_timer_tb.sv */
// self-checking bench for the watchdog / interval timer
// assumes wit_pkg and the timer modules under rtl/ are compiled first

`default_nettype none

module wit_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import wit_pkg::*;

	// ****************************************************************
	// clock, stimulus and design
	// ****************************************************************
	logic            clock;
	logic            rst;
	logic            ext_reset_n;
	logic            standby;
	wit_bus_req_type bus;
	logic [7:0]      rdata;
	logic            rvalid;
	logic            overflow_n;
	logic            chip_reset;
	logic            interrupt;
	int              failures;
	int              n_checks;

	wit_timer i_wit_timer (
		.i_clock              (clock),
		.i_rst                (rst),
		.i_external_reset_n   (ext_reset_n),
		.i_standby            (standby),
		.i_bus                (bus),
		.o_rdata              (rdata),
		.o_rvalid             (rvalid),
		.o_overflow_n         (overflow_n),
		.o_chip_reset         (chip_reset),
		.o_interval_interrupt (interrupt)
	);

	// free running 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ****************************************************************
	// compare, bus and wait helpers
	// ****************************************************************
	task automatic check_byte(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_int(input string name, input int exp, input int got);
		n_checks++;
		if (got != exp)
		begin
			failures++;
			$display("[FAIL] %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	// one write strobe, held for exactly one taking edge
	task automatic wr(input logic [31:0] addr, input logic [15:0] data,
		input logic word = 1'b1);
		@(posedge clock);
		#1;
		bus = '{addr: addr, write: 1'b1, read: 1'b0, word: word, wdata: data};
		@(posedge clock);
		#1;
		bus.write = 1'b0;
	endtask

	// byte read; answer stands in the cycle after the taking edge
	task automatic rd(input logic [31:0] addr, output logic [7:0] data);
		@(posedge clock);
		#1;
		bus = '{addr: addr, write: 1'b0, read: 1'b1, word: 1'b0, wdata: 16'h0};
		@(posedge clock);
		#1;
		bus.read = 1'b0;
		check_byte("read valid", 8'h01, {7'h00, rvalid});
		data = rdata;
	endtask

	task automatic rd_chk(input logic [31:0] addr, input logic [7:0] exp,
		input string name);
		logic [7:0] v;
		rd(addr, v);
		check_byte(name, exp, v);
	endtask

	task automatic wait_for(ref logic sig, input logic lvl, input int limit);
		int n;
		n = 0;
		while (sig !== lvl && n < limit)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		check_int("wait bound", 1, int'(n < limit));
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset_values();
		rd_chk(ADDR_CTRL_RD, 8'h18, "control reset");
		rd_chk(ADDR_COUNT_RD, 8'h00, "count reset");
		rd_chk(ADDR_RESET_CTRL_RD, 8'h1f, "reset reg reset");
		rd_chk(32'hffff8614, 8'h00, "unmapped read");
		$display("test reset values done");
	endtask

	task automatic t_keys();
		wr(ADDR_COUNT_CTRL_WR, 16'ha527);
		rd_chk(ADDR_CTRL_RD, 8'h3f, "control by key");
		wr(ADDR_COUNT_CTRL_WR, 16'h5a42);
		rd_chk(ADDR_COUNT_RD, 8'h42, "count by key");
		wr(ADDR_COUNT_CTRL_WR, 16'h5a10, 1'b0);
		wr(ADDR_COUNT_CTRL_WR, 16'h3c11);
		wr(ADDR_RESET_CTRL_WR, 16'h3c40);
		wr(ADDR_RESET_CTRL_WR, 16'h5a40, 1'b0);
		rd_chk(ADDR_COUNT_RD, 8'h42, "count after refused");
		rd_chk(ADDR_CTRL_RD, 8'h3f, "control after refused");
		rd_chk(ADDR_RESET_CTRL_RD, 8'h1f, "reset reg refused");
		wr(ADDR_COUNT_CTRL_WR, 16'ha518);
		rd_chk(ADDR_COUNT_RD, 8'h00, "count held when off");
		$display("test keys done");
	endtask

	task automatic t_clock_select();
		int         div [8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
		logic [7:0] v;
		for (int k = 0; k < 8; k++)
		begin
			wr(ADDR_COUNT_CTRL_WR, {KEY_CONTROL, 5'b00011, k[2:0]});
			wr(ADDR_COUNT_CTRL_WR, {KEY_CONTROL, 5'b00111, k[2:0]});
			repeat (4 * div[k]) @(posedge clock);
			rd(ADDR_COUNT_RD, v);
			check_int("ticks in window", 1, int'(v >= 3 && v <= 5));
		end
		wr(ADDR_COUNT_CTRL_WR, 16'ha518);
		$display("test clock select done");
	endtask

	task automatic t_interval();
		wr(ADDR_COUNT_CTRL_WR, 16'ha520);
		wr(ADDR_COUNT_CTRL_WR, 16'h5afe);
		wait_for(interrupt, 1'b1, 20);
		check_byte("no overflow output", 8'h01, {7'h00, overflow_n});
		wr(ADDR_COUNT_CTRL_WR, 16'ha520);
		check_byte("clear needs read", 8'h01, {7'h00, interrupt});
		rd_chk(ADDR_CTRL_RD, 8'hb8, "interval flag");
		rd_chk(ADDR_RESET_CTRL_RD, 8'h1f, "no watchdog flag");
		wr(ADDR_COUNT_CTRL_WR, 16'ha518);
		check_byte("interrupt cleared", 8'h00, {7'h00, interrupt});
		rd_chk(ADDR_COUNT_RD, 8'h00, "count stopped");
		$display("test interval done");
	endtask

	task automatic t_watchdog();
		int lo;
		int hi;
		wr(ADDR_RESET_CTRL_WR, 16'h5a40);
		rd_chk(ADDR_RESET_CTRL_RD, 8'h5f, "chip reset enable");
		wr(ADDR_COUNT_CTRL_WR, 16'ha560);
		wr(ADDR_COUNT_CTRL_WR, 16'h5afd);
		wait_for(overflow_n, 1'b0, 50);
		lo = 0;
		hi = 0;
		repeat (600)
		begin
			lo += int'(overflow_n === 1'b0);
			hi += int'(chip_reset === 1'b1);
			@(posedge clock);
			#1;
		end
		check_int("overflow output cycles", 128, lo);
		check_int("chip reset cycles", 512, hi);
		check_byte("no interrupt", 8'h00, {7'h00, interrupt});
		rd_chk(ADDR_RESET_CTRL_RD, 8'hdf, "watchdog flag");
		rd_chk(ADDR_CTRL_RD, 8'h18, "control after overflow");
		rd_chk(ADDR_COUNT_RD, 8'h00, "count after overflow");
		wr(ADDR_RESET_CTRL_WR, 16'ha500);
		rd_chk(ADDR_RESET_CTRL_RD, 8'h5f, "flag clear keeps enable");
		wr(ADDR_RESET_CTRL_WR, 16'h5a00);
		rd_chk(ADDR_RESET_CTRL_RD, 8'h1f, "enable cleared");
		$display("test watchdog done");
	endtask

	task automatic t_standby_and_pin();
		wr(ADDR_COUNT_CTRL_WR, 16'ha505);
		wr(ADDR_RESET_CTRL_WR, 16'h5a40);
		@(posedge clock);
		#1;
		standby = 1'b1;
		@(posedge clock);
		#1;
		standby = 1'b0;
		rd_chk(ADDR_CTRL_RD, 8'h1d, "standby keeps select");
		rd_chk(ADDR_RESET_CTRL_RD, 8'h1f, "standby reset reg");
		wr(ADDR_COUNT_CTRL_WR, 16'ha506);
		wr(ADDR_RESET_CTRL_WR, 16'h5a40);
		ext_reset_n = 1'b0;
		repeat (3) @(posedge clock);
		#1;
		ext_reset_n = 1'b1;
		repeat (4) @(posedge clock);
		rd_chk(ADDR_RESET_CTRL_RD, 8'h1f, "pin reset reg");
		rd_chk(ADDR_CTRL_RD, 8'h18, "pin reset control");
		$display("test standby and pin done");
	endtask

	// ****************************************************************
	// verdict, sequence and watchdog
	// ****************************************************************
	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// main sequence after a five cycle power-on reset
	initial
	begin
		failures = 0;
		n_checks = 0;
		rst = 1'b1;
		ext_reset_n = 1'b1;
		standby = 1'b0;
		bus = '0;
		repeat (5) @(posedge clock);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge clock);
		t_reset_values();
		t_keys();
		t_interval();
		t_watchdog();
		t_standby_and_pin();
		t_clock_select();
		stop_test();
	end

	// hang guard, well beyond the longest expected run
	initial
	begin
		#800us;
		failures++;
		$display("watchdog expired");
		stop_test();
	end

endmodule

`default_nettype wire
